// *** design/tmr2_fall_det.sv ***
// Purpose: falling edge detector for a sampled pin
// Assumes: pin already synchronous to the clock
// Notes: a pin already low after reset reads as a falling edge, history starts high
`timescale 1ns/1ps
`default_nettype none
module tmr2_fall_det (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic pin_i,
    output logic      fall_o
);
    logic last; // previous pin level
    // history register; reset high so a pin low after reset reads as an edge
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last <= 1'b1;
        end else begin
            last <= pin_i;
        end
    end
    assign fall_o = last & ~pin_i;
endmodule : tmr2_fall_det
`default_nettype wire

// *** design/tmr2_pkg.sv ***
// Purpose: constants for the capture/reload/baud timer
// Assumes: 8-bit special function register access, 25 MHz core clock
// Notes: register addresses are special function space addresses
package tmr2_pkg;
    localparam logic [7:0] TMR2_ADDR_CTRL  = 8'hc8; // timer control
    localparam logic [7:0] TMR2_ADDR_PULSE = 8'hc9; // pulse out control
    localparam logic [7:0] TMR2_ADDR_RLL   = 8'hca; // reload low byte
    localparam logic [7:0] TMR2_ADDR_RLH   = 8'hcb; // reload high byte
    localparam logic [7:0] TMR2_ADDR_CNTL  = 8'hcc; // count low byte
    localparam logic [7:0] TMR2_ADDR_CNTH  = 8'hcd; // count high byte
    // control register field positions
    localparam int TMR2_B_OVF  = 7;
    localparam int TMR2_B_EXT  = 6;
    localparam int TMR2_B_RCLK = 5;
    localparam int TMR2_B_TRANSMIT_CLOCK_SELECT = 4;
    localparam int TMR2_B_EXEN = 3;
    localparam int TMR2_B_RUN  = 2;
    localparam int TMR2_B_CT   = 1;
    localparam int TMR2_B_CPRL = 0;
    localparam int TMR2_B_POE  = 1; // pulse output enable bit
    localparam logic [7:0] TMR2_CTRL_RST = 8'h00;
    localparam logic [7:0] TMR2_RELOAD_RST = 8'h00;
    // prescale counts in core clocks
    localparam logic [3:0] TMR2_DIV_FAST = 4'h4;
    localparam logic [3:0] TMR2_DIV_SLOW = 4'hc;
    localparam logic [3:0] TMR2_DIV_BAUD = 4'h2;
    localparam logic [3:0] TMR2_BAUD_DIV = 4'hf; // divide-by-16 top
    localparam logic [15:0] TMR2_CNT_MAX = 16'hffff;
    typedef enum logic [1:0] {
        TMR2_MODE_PLAIN,
        TMR2_MODE_CAPTURE,
        TMR2_MODE_RELOAD,
        TMR2_MODE_BAUD
    } tmr2_mode_t;
endpackage : tmr2_pkg

// *** design/tmr2_timer.sv ***
// Purpose: 16-bit timer with capture, auto-reload and baud generation
// Assumes: one write or read strobe at a time on the register port
// Notes: count bytes are unsafe to touch while generating baud clocks
`timescale 1ns/1ps
`default_nettype none
module tmr2_timer
    import tmr2_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       count_input_pin_i,
    input  wire logic       external_trigger_pin_i,
    input  wire logic       pin_alt_function_option_i,
    output logic            shared_port_pin_o,
    output logic            overflow_pulse_o,
    output logic            baud_tick_o,
    output logic            tx_clock_o,
    output logic            rx_clock_o,
    output logic            irq_request_o
);
    logic [7:0]  timer_control_reg;       // control and flags
    logic        pulse_output_enable;     // pulse enable, bit 1 of pulse control
    logic [7:0]  count_low_byte;
    logic [7:0]  count_high_byte;
    logic [7:0]  reload_low_byte;
    logic [7:0]  reload_high_byte;
    logic [3:0]  pre_cnt;                 // prescaler
    logic [3:0]  baud_cnt;                // divide-by-16 chain
    logic        cnt_fall;                // count pin falling edge
    logic        trg_fall;                // trigger pin falling edge
    logic        ovf_q;                   // registered overflow pulse
    logic        forced_irq;              // one-written flag request
    tmr2_mode_t  mode;
    logic        baud_mode;
    logic        run;
    logic        exen;
    logic        tick;                    // counter advance strobe
    logic        wrap;                    // counter wraps this cycle
    logic        trg_evt;                 // qualified trigger edge
    logic [15:0] count;
    logic [15:0] reload;
    logic [3:0]  pre_top;
    logic        prescale_select;         // 1: every 4, 0: every 12
    logic        wr_ctrl;
    logic        wr_pulse;

    // address match helper, used by every write strobe
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    tmr2_fall_det u_cnt_fall (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .pin_i      (count_input_pin_i),
        .fall_o     (cnt_fall)
    );

    tmr2_fall_det u_trg_fall (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .pin_i      (external_trigger_pin_i),
        .fall_o     (trg_fall)
    );

    assign count  = {count_high_byte, count_low_byte};
    assign reload = {reload_high_byte, reload_low_byte};
    assign run    = timer_control_reg[TMR2_B_RUN];
    assign exen   = timer_control_reg[TMR2_B_EXEN];
    assign wr_ctrl  = sfr_wr_i & hit(sfr_addr_i, TMR2_ADDR_CTRL);
    assign wr_pulse = sfr_wr_i & hit(sfr_addr_i, TMR2_ADDR_PULSE);

    // mode decode; clock select bits win over capture select
    always_comb begin
        baud_mode = timer_control_reg[TMR2_B_RCLK]
                  | timer_control_reg[TMR2_B_TRANSMIT_CLOCK_SELECT];
        if (baud_mode) begin
            mode = TMR2_MODE_BAUD;
        end else if (timer_control_reg[TMR2_B_CPRL]) begin
            // capture needs the trigger enabled to differ from plain
            mode = exen ? TMR2_MODE_CAPTURE : TMR2_MODE_PLAIN;
        end else begin
            mode = TMR2_MODE_RELOAD;
        end
    end

    // prescale top: baud ignores the prescale select input
    always_comb begin
        if (baud_mode) begin
            pre_top = TMR2_DIV_BAUD;
        end else if (prescale_select) begin
            pre_top = TMR2_DIV_FAST;
        end else begin
            pre_top = TMR2_DIV_SLOW;
        end
    end

    // prescale select lives in the clock control register elsewhere;
    // here it is held as bit 5 of the pulse control register

    // advance strobe; counter mode uses the count pin except in baud
    always_comb begin
        if (!run) begin
            tick = 1'b0;
        end else if (timer_control_reg[TMR2_B_CT] && !baud_mode) begin
            tick = cnt_fall;
        end else begin
            tick = (pre_cnt == pre_top - 4'h1);
        end
    end

    assign wrap = tick & (count == TMR2_CNT_MAX);

    assign trg_evt = exen & trg_fall;

    // prescaler, free running while enabled
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_cnt <= 4'h0;
        end else if (!run || (pre_cnt >= pre_top - 4'h1)) begin
            pre_cnt <= 4'h0;
        end else begin
            pre_cnt <= pre_cnt + 4'h1;
        end
    end

    // count bytes: reloads, increments and software writes
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_low_byte  <= 8'h00;
            count_high_byte <= 8'h00;
        end else if (wrap && mode == TMR2_MODE_BAUD) begin
            {count_high_byte, count_low_byte} <= reload;
        end else if (wrap && mode == TMR2_MODE_RELOAD) begin
            {count_high_byte, count_low_byte} <= reload;
        end else if (trg_evt && mode == TMR2_MODE_RELOAD) begin
            {count_high_byte, count_low_byte} <= reload;
        end else if (tick) begin
            {count_high_byte, count_low_byte} <= count + 16'h0001;
        end else if (sfr_wr_i && hit(sfr_addr_i, TMR2_ADDR_CNTL)) begin
            count_low_byte <= sfr_wdata_i;
        end else if (sfr_wr_i && hit(sfr_addr_i, TMR2_ADDR_CNTH)) begin
            count_high_byte <= sfr_wdata_i;
        end
    end

    // reload/capture pair; capture wins over a software write
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reload_low_byte  <= TMR2_RELOAD_RST;
            reload_high_byte <= TMR2_RELOAD_RST;
        end else if (trg_evt && mode == TMR2_MODE_CAPTURE) begin
            reload_low_byte  <= count_low_byte;
            reload_high_byte <= count_high_byte;
        end else if (sfr_wr_i && hit(sfr_addr_i, TMR2_ADDR_RLL)) begin
            reload_low_byte <= sfr_wdata_i;
        end else if (sfr_wr_i && hit(sfr_addr_i, TMR2_ADDR_RLH)) begin
            reload_high_byte <= sfr_wdata_i;
        end
    end

    // control register; hardware set beats a software clear
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer_control_reg <= TMR2_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                timer_control_reg <= sfr_wdata_i;
            end
            if (wrap && !baud_mode) begin
                timer_control_reg[TMR2_B_OVF] <= 1'b1;
            end
            if (trg_evt) begin
                timer_control_reg[TMR2_B_EXT] <= 1'b1;
            end
        end
    end

    // forced request when software writes a one to either flag
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            forced_irq <= 1'b0;
        end else begin
            forced_irq <= wr_ctrl
                        & (sfr_wdata_i[TMR2_B_OVF] | sfr_wdata_i[TMR2_B_EXT]);
        end
    end

    // pulse control register and prescale select bit
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_output_enable <= 1'b0;
            prescale_select     <= 1'b0;
        end else if (wr_pulse) begin
            pulse_output_enable <= sfr_wdata_i[TMR2_B_POE];
            prescale_select     <= sfr_wdata_i[5];
        end
    end

    // registered overflow pulse, one core clock wide
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= wrap;
        end
    end

    // divide-by-16 of overflows for the uart bit clock
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            baud_cnt    <= 4'h0;
            baud_tick_o <= 1'b0;
        end else begin
            baud_tick_o <= 1'b0;
            if (wrap && baud_mode) begin
                baud_cnt    <= baud_cnt + 4'h1;
                baud_tick_o <= (baud_cnt == TMR2_BAUD_DIV);
            end
        end
    end

    // uart clock selects route the divided tick
    assign tx_clock_o = baud_tick_o & timer_control_reg[TMR2_B_TRANSMIT_CLOCK_SELECT];
    assign rx_clock_o = baud_tick_o & timer_control_reg[TMR2_B_RCLK];
    assign overflow_pulse_o = ovf_q;

    assign shared_port_pin_o = ovf_q & pulse_output_enable
                             & pin_alt_function_option_i;

    // sticky flags plus forced request; mask lives in the interrupt unit
    assign irq_request_o = timer_control_reg[TMR2_B_OVF]
                         | timer_control_reg[TMR2_B_EXT] | forced_irq;

    // read data registered; unmapped addresses read zero
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (!sfr_rd_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (hit(sfr_addr_i, TMR2_ADDR_CTRL)) begin
            sfr_rdata_o <= timer_control_reg;
        end else if (hit(sfr_addr_i, TMR2_ADDR_PULSE)) begin
            sfr_rdata_o <= {2'b00, prescale_select, 3'b000,
                            pulse_output_enable, 1'b0};
        end else if (hit(sfr_addr_i, TMR2_ADDR_RLL)) begin
            sfr_rdata_o <= reload_low_byte;
        end else if (hit(sfr_addr_i, TMR2_ADDR_RLH)) begin
            sfr_rdata_o <= reload_high_byte;
        end else if (hit(sfr_addr_i, TMR2_ADDR_CNTL)) begin
            sfr_rdata_o <= count_low_byte;
        end else if (hit(sfr_addr_i, TMR2_ADDR_CNTH)) begin
            sfr_rdata_o <= count_high_byte;
        end else begin
            sfr_rdata_o <= 8'h00;
        end
    end
endmodule : tmr2_timer
`default_nettype wire

// *** verification/timer2_capture_reload_baud_tb.sv ***
// Purpose: self-checking bench for the capture/reload/baud timer
// Assumes: strobes raised 1 ns after a rising edge
// Notes: periods measured between registered overflow pulses or tx clock pulses
`timescale 1ns/1ps
`default_nettype none
module timer2_capture_reload_baud_tb;
    import tmr2_pkg::*;
    logic        core_clk, arst_n, wr, rd, fire, opt;
    logic [7:0]  addr, wdata, rdata, v, lo;
    logic        trig, cnt, pin, ovf, tick, txc, rxc, irq;
    logic [31:0] seed; // xorshift state
    logic [15:0] rl;   // reload value under test
    int          n_fail, samples_checked, n;
    tmr2_timer tmr2_timer_inst (.core_clk_i(core_clk), .arst_n_i(arst_n),
        .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_rdata_o(rdata), .count_input_pin_i(cnt),
        .external_trigger_pin_i(trig), .pin_alt_function_option_i(opt),
        .shared_port_pin_o(pin), .overflow_pulse_o(ovf),
        .baud_tick_o(tick), .tx_clock_o(txc), .rx_clock_o(rxc),
        .irq_request_o(irq));
    tmr2_far_end tmr2_far_end_inst (.core_clk_i(core_clk), .arst_n_i(arst_n),
        .fire_i(fire), .trig_o(trig), .count_o(cnt));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // overflow period in core clocks for a reload value and prescale
    function automatic logic [15:0] per(input logic [15:0] r, input int d);
        return 16'((32'h10000 - {16'h0, r}) * d);
    endfunction : per
    task automatic conclude();
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge core_clk) #1 wr = 1'b0;
        @(posedge core_clk) #1;
    endtask : wrr
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        @(posedge core_clk) #1 d = rdata;
        rd = 1'b0;
        @(posedge core_clk) #1;
    endtask : rdr
    task automatic trigger();
        fire = 1'b1;
        @(posedge core_clk) #1 fire = 1'b0;
        repeat (5) @(posedge core_clk) #1;
    endtask : trigger
    // bounded wait for one overflow pulse
    task automatic wt();
        int k;
        for (k = 0; k < 9000 && ovf !== 1'b1; k++)
            @(posedge core_clk) #1;
        if (k >= 9000) begin
            n_fail++;
            conclude();
        end
    endtask : wt
    // wait for a pulse, then count cycles to the next one (bounded)
    task automatic meas(input bit s, output int k);
        for (k = 0; k < 9000 && (s ? txc : ovf) !== 1'b1; k++)
            @(posedge core_clk) #1;
        if (k < 9000) begin
            k = 0;
            do begin
                @(posedge core_clk) #1;
                k++;
            end while ((s ? txc : ovf) !== 1'b1 && k < 9000);
        end
        if (k >= 9000) begin
            n_fail++;
            conclude();
        end
    endtask : meas
    initial begin
        {arst_n, wr, rd, fire, opt} = 5'h00;
        addr = 8'h00;
        wdata = 8'h00;
        seed = 32'h54365130;
        n_fail = 0;
        samples_checked = 0;
        repeat (3) @(posedge core_clk);
        #1 arst_n = 1'b1;
        rdr(TMR2_ADDR_CTRL, v); chk(v, 8'h00);
        rdr(TMR2_ADDR_PULSE, v); chk(v & 8'h02, 8'h00);
        rdr(8'hce, v); chk(v, 8'h00);
        opt = 1'b1;
        // slow then fast prescale in auto-reload mode
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            // span kept long so a flag clear never meets a wrap
            rl = {9'h1fe, seed[6:0]};
            wrr(TMR2_ADDR_PULSE, (i == 1) ? 8'h22 : 8'h02);
            wrr(TMR2_ADDR_CTRL, 8'h00);
            wrr(TMR2_ADDR_RLL, rl[7:0]);
            wrr(TMR2_ADDR_RLH, rl[15:8]);
            wrr(TMR2_ADDR_CNTL, 8'hff);
            wrr(TMR2_ADDR_CNTH, 8'hff);
            wrr(TMR2_ADDR_CTRL, 8'h04);
            meas(1'b0, n); chk(16'(n), per(rl, (i == 1) ? 4 : 12));
            rdr(TMR2_ADDR_CTRL, v); chk(v, 8'h84);
            wrr(TMR2_ADDR_CTRL, 8'h04);
            rdr(TMR2_ADDR_CTRL, v); chk(v, 8'h04);
        end
        // plain mode wraps to zero, reload pair left alone
        wrr(TMR2_ADDR_CTRL, 8'h01);
        wrr(TMR2_ADDR_CNTL, 8'hff);
        wrr(TMR2_ADDR_CNTH, 8'hff);
        wrr(TMR2_ADDR_CTRL, 8'h05);
        wt();
        rdr(TMR2_ADDR_CTRL, v); chk(v, 8'h85);
        wrr(TMR2_ADDR_CTRL, 8'h01);
        rdr(TMR2_ADDR_CNTH, v); chk(v, 8'h00);
        rdr(TMR2_ADDR_RLL, v); chk(v, rl[7:0]);
        // capture of a stopped count on a trigger edge
        seed = xs(seed);
        lo = seed[7:0] | 8'h01;
        wrr(TMR2_ADDR_CTRL, 8'h09);
        wrr(TMR2_ADDR_CNTL, lo);
        wrr(TMR2_ADDR_CNTH, seed[15:8]);
        trigger();
        rdr(TMR2_ADDR_RLL, v); chk(v, lo);
        rdr(TMR2_ADDR_RLH, v); chk(v, seed[15:8]);
        rdr(TMR2_ADDR_CTRL, v); chk(v, 8'h49);
        // trigger disabled: edge ignored
        wrr(TMR2_ADDR_CTRL, 8'h01);
        wrr(TMR2_ADDR_RLL, 8'h00);
        trigger();
        rdr(TMR2_ADDR_RLL, v); chk(v, 8'h00);
        rdr(TMR2_ADDR_CTRL, v); chk(v, 8'h01);
        // auto-reload from the trigger edge
        wrr(TMR2_ADDR_CTRL, 8'h08);
        wrr(TMR2_ADDR_RLL, seed[23:16]);
        wrr(TMR2_ADDR_RLH, seed[31:24]);
        trigger();
        rdr(TMR2_ADDR_CNTL, v); chk(v, seed[23:16]);
        rdr(TMR2_ADDR_CNTH, v); chk(v, seed[31:24]);
        rdr(TMR2_ADDR_CTRL, v); chk(v, 8'h48);
        // timer stopped before the reload pair is written
        wrr(TMR2_ADDR_CTRL, 8'h00);
        wrr(TMR2_ADDR_RLL, 8'hf0);
        wrr(TMR2_ADDR_RLH, 8'hff);
        wrr(TMR2_ADDR_CNTL, 8'hf0);
        wrr(TMR2_ADDR_CNTH, 8'hff);
        // count bytes left alone once baud runs
        wrr(TMR2_ADDR_CTRL, 8'h3c);
        meas(1'b0, n); chk(16'(n), per(16'hfff0, 2));
        meas(1'b1, n); chk(16'(n), per(16'hfff0, 32));
        rdr(TMR2_ADDR_CTRL, v); chk(v, 8'h3c);
        trigger();
        rdr(TMR2_ADDR_CTRL, v); chk(v, 8'h7c);
        conclude();
    end
endmodule : timer2_capture_reload_baud_tb
`default_nettype wire

// *** verification/tmr2_far_end.sv ***
// Purpose: far-side pins: trigger source and count pin
// Assumes: pins sampled on the core clock rising edge
// Notes: trigger held low three cycles so no edge is lost
`timescale 1ns/1ps
`default_nettype none
module tmr2_far_end (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic fire_i,
    output logic      trig_o,
    output logic      count_o
);
    logic [1:0] hold; // remaining low cycles of the trigger
    // one falling edge per request, then back to idle high
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold <= 2'h0;
        end else if (fire_i) begin
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end
    assign trig_o  = (hold == 2'h0);
    assign count_o = 1'b1; // idle level, counter mode left unused
endmodule : tmr2_far_end
`default_nettype wire

// *** verification/tmr2_timer_props.sv ***
// Purpose: port-level checks for the capture/reload/baud timer
// Assumes: register writes seen on the bus are the only mode changes
// Notes: shadows of mode bits track writes, flags are not shadowed
`timescale 1ns/1ps
`default_nettype none
module tmr2_timer_props
    import tmr2_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_rdata_o,
    input  wire logic       pin_alt_function_option_i,
    input  wire logic       shared_port_pin_o,
    input  wire logic       overflow_pulse_o,
    input  wire logic       baud_tick_o,
    input  wire logic       tx_clock_o,
    input  wire logic       rx_clock_o,
    input  wire logic       irq_request_o
);
    logic rclk_sh; // shadow of receive clock select
    logic transmit_clock_select_sh; // shadow of transmit clock select
    logic poe_sh;  // shadow of pulse output enable
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    // follow control writes so mode is known at the ports
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rclk_sh <= 1'b0;
            transmit_clock_select_sh <= 1'b0;
        end else if (sfr_wr_i && sfr_addr_i == TMR2_ADDR_CTRL) begin
            rclk_sh <= sfr_wdata_i[TMR2_B_RCLK];
            transmit_clock_select_sh <= sfr_wdata_i[TMR2_B_TRANSMIT_CLOCK_SELECT];
        end
    end
    // follow pulse control writes
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            poe_sh <= 1'b0;
        end else if (sfr_wr_i && sfr_addr_i == TMR2_ADDR_PULSE) begin
            poe_sh <= sfr_wdata_i[TMR2_B_POE];
        end
    end
    chk_pin_gated: assert property (
        shared_port_pin_o |-> overflow_pulse_o && poe_sh
            && pin_alt_function_option_i) else $error("pin pulse ungated");
    chk_pin_forwards: assert property (
        overflow_pulse_o && poe_sh && pin_alt_function_option_i
            |-> shared_port_pin_o) else $error("pin pulse missing");
    chk_pulse_single: assert property (
        overflow_pulse_o |=> !overflow_pulse_o)
        else $error("overflow pulse too long");
    chk_tick_spacing: assert property (
        baud_tick_o |=> !baud_tick_o [*8]) else $error("baud ticks too close");
    chk_tx_gate: assert property (
        tx_clock_o |-> transmit_clock_select_sh && baud_tick_o) else $error("tx clock ungated");
    chk_rx_gate: assert property (
        rx_clock_o |-> rclk_sh && baud_tick_o) else $error("rx clock ungated");
    chk_ovf_irq: assert property (
        overflow_pulse_o && !(rclk_sh || transmit_clock_select_sh) |-> ##[0:1] irq_request_o)
        else $error("overflow raised no request");
    chk_rdata_quiet: assert property (
        !$past(sfr_rd_i) || $past(sfr_addr_i) < 8'hc8
            || $past(sfr_addr_i) > 8'hcd |-> sfr_rdata_o == 8'h00)
        else $error("read data not zero");
endmodule : tmr2_timer_props
bind tmr2_timer tmr2_timer_props tmr2_timer_props_inst (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o),
    .pin_alt_function_option_i(pin_alt_function_option_i),
    .shared_port_pin_o(shared_port_pin_o),
    .overflow_pulse_o(overflow_pulse_o), .baud_tick_o(baud_tick_o),
    .tx_clock_o(tx_clock_o), .rx_clock_o(rx_clock_o),
    .irq_request_o(irq_request_o));
`default_nettype wire
